//--- rtl/gpc_pin_config_bank.sv
// Chosen here: the Avalon-MM register port.
`include "gpc_params.svh"

// Notes on behaviour
// RULE_01 - Second-port select moves pin 3 register control to second port pin 3.
// RULE_02 - Local level drives pad only in GPIO output mode without remote drive.
// RULE_03 - Pin 3 remote enable forces output carrying the remote serializer value.
// RULE_04 - Code {orientation,enable}: 00 functional, 10 tri-state, 01 GPIO out, 11 in.
// RULE_05 - Pin 3 orientation and enable come up as 1 when select is high.
// RULE_06 - Upper pin uses bits 7, 5, 4; lower pin uses bits 3, 1, 0.
// RULE_07 - Bit 0 pairs with bit 1 to form the lower pin mode code.
// RULE_08 - Pins 7/8 at 0x21 resetting to zero; pins 5/6 at 0x20.
// RULE_09 - Reserved bits read zero after reset and never affect pads.
module gpc_pin_config_bank #(
  parameter int ADDR_W = 8                   // Avalon byte address width
) (
  input  wire logic              clk_i,                // System clock, 40 MHz
  input  wire logic              sys_rst_i,            // Async reset, active high
  input  wire logic [ADDR_W-1:0] avs_address_i,        // Byte address
  input  wire logic              avs_read_i,           // Read request
  input  wire logic              avs_write_i,          // Write request
  input  wire logic [31:0]       avs_writedata_i,      // Write data
  input  wire logic [3:0]        avs_byteenable_i,     // Byte enables
  output logic      [31:0]       avs_readdata_o,       // Read data
  output logic                   avs_waitrequest_o,    // Wait request
  input  wire logic              second_port_select_i, // Second-port select
  input  wire logic              remote_pin3_i,        // Remote value for pin 3
  input  wire logic [5:0]        func_i,               // Functional outputs
  input  wire logic [5:0]        pad_i,                // Pad input levels
  output logic      [5:0]        pad_o,                // Pad output levels
  output logic      [5:0]        pad_oe_n_o            // Pad drive enables, low drives
);
  import gpc_pkg::*;

  // ********************************************************************
  // Bus decode
  // ********************************************************************
  logic       wait_q;
  logic       wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [7:0] pin3_config_q;
  logic [7:0] pin3_config_d;
  logic [7:0] pins5_6_config_q;
  logic [7:0] pins5_6_config_d;
  logic [7:0] pins7_8_config_q;
  logic [7:0] pins7_8_config_d;
  logic       init_q;
  logic [5:0] in_levels;

  wire [5:0] reg_idx   = avs_address_i[7:2];
  wire       bus_req   = avs_read_i | avs_write_i;
  wire       capture   = bus_req & wait_q;
  wire       wr_fire   = avs_write_i & ~wait_q & avs_byteenable_i[0];
  wire       hit_pin3  = (reg_idx == `GPC_IDX_PIN3);
  wire       hit_p56   = (reg_idx == `GPC_IDX_PINS5_6);              // see RULE_08
  wire       hit_p78   = (reg_idx == `GPC_IDX_PINS7_8);              // see RULE_08
  wire       hit_inlvl = (reg_idx == `GPC_IDX_IN_LEVELS);
  wire       wr_pin3   = wr_fire & hit_pin3;
  wire       wr_p56    = wr_fire & hit_p56;
  wire       wr_p78    = wr_fire & hit_p78;

  // One wait state: request seen, answer next cycle, then idle again
  assign wait_d = ~capture;

  // Unmapped addresses read as zero and swallow writes
  wire [7:0] rd_byte = hit_pin3  ? pin3_config_q :
                       hit_p56   ? pins5_6_config_q :
                       hit_p78   ? pins7_8_config_q :
                       hit_inlvl ? {2'h0, in_levels} : 8'h00;
  assign rdata_d = capture ? {24'h000000, rd_byte} : rdata_q;

  // ********************************************************************
  // Configuration registers
  // ********************************************************************
  // Strap is taken one edge after reset release, never by the reset itself
  wire [1:0] pin3_boot_code = second_port_select_i ? `GPC_STRAP_CODE :       // see RULE_05
                                                     pin3_config_q[1:0];
  // Upper nibble of pin 3 is read-only zero
  assign pin3_config_d = !init_q ? {pin3_config_q[7:2], pin3_boot_code} :     // see RULE_05
                         wr_pin3 ? (avs_writedata_i[7:0] & `GPC_PIN3_RW_MASK) : // see RULE_09
                                   pin3_config_q;
  assign pins5_6_config_d = wr_p56 ? avs_writedata_i[7:0] : pins5_6_config_q;  // see RULE_08
  assign pins7_8_config_d = wr_p78 ? avs_writedata_i[7:0] : pins7_8_config_q;  // see RULE_08

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_q           <= 1'b1;
      rdata_q          <= 32'h00000000;
      init_q           <= 1'b0;
      pin3_config_q    <= `GPC_RST_CFG;
      pins5_6_config_q <= `GPC_RST_CFG;
      pins7_8_config_q <= `GPC_RST_CFG;
    end else begin
      wait_q           <= wait_d;
      rdata_q          <= rdata_d;
      init_q           <= 1'b1;
      pin3_config_q    <= pin3_config_d;
      pins5_6_config_q <= pins5_6_config_d;
      pins7_8_config_q <= pins7_8_config_d;
    end
  end

  assign avs_waitrequest_o = wait_q;
  assign avs_readdata_o    = rdata_q;

  // ********************************************************************
  // Per-pad field selection
  // ********************************************************************
  // Pad order: 0 pin 3, 1 second port pin 3, 2 pin 5, 3 pin 6, 4 pin 7, 5 pin 8
  logic [5:0] level_w;
  logic [5:0] orient_w;
  logic [5:0] enable_w;
  logic [5:0] remote_w;

  // The pad not steered by the select is parked in tri-state
  wire sel = second_port_select_i;
  wire p3_lvl = pin3_config_q[`GPC_LO_LEVEL];
  wire p3_rem = pin3_config_q[`GPC_LO_REMOTE];
  wire p3_dir = pin3_config_q[`GPC_LO_DIR];
  wire p3_en  = pin3_config_q[`GPC_LO_EN];

  assign level_w[0]  = sel ? 1'b0 : p3_lvl;                                   // see RULE_01
  assign orient_w[0] = sel ? 1'b1 : p3_dir;                                   // see RULE_01
  assign enable_w[0] = sel ? 1'b0 : p3_en;                                    // see RULE_01
  assign remote_w[0] = sel ? 1'b0 : p3_rem;                                   // see RULE_01
  assign level_w[1]  = sel ? p3_lvl : 1'b0;                                   // see RULE_01
  assign orient_w[1] = sel ? p3_dir : 1'b1;                                   // see RULE_01
  assign enable_w[1] = sel ? p3_en  : 1'b0;                                   // see RULE_01
  assign remote_w[1] = sel ? p3_rem : 1'b0;                                   // see RULE_01

  // Bits 6 and 2 of the dual registers are stored but never reach a pad
  assign level_w[2]  = pins5_6_config_q[`GPC_LO_LEVEL];                      // see RULE_06
  assign orient_w[2] = pins5_6_config_q[`GPC_LO_DIR];                        // see RULE_07
  assign enable_w[2] = pins5_6_config_q[`GPC_LO_EN];                         // see RULE_07
  assign level_w[3]  = pins5_6_config_q[`GPC_HI_LEVEL];                      // see RULE_06
  assign orient_w[3] = pins5_6_config_q[`GPC_HI_DIR];                        // see RULE_06
  assign enable_w[3] = pins5_6_config_q[`GPC_HI_EN];                         // see RULE_06
  assign level_w[4]  = pins7_8_config_q[`GPC_LO_LEVEL];                      // see RULE_06
  assign orient_w[4] = pins7_8_config_q[`GPC_LO_DIR];                        // see RULE_07
  assign enable_w[4] = pins7_8_config_q[`GPC_LO_EN];                         // see RULE_07
  assign level_w[5]  = pins7_8_config_q[`GPC_HI_LEVEL];                      // see RULE_06
  assign orient_w[5] = pins7_8_config_q[`GPC_HI_DIR];                        // see RULE_06
  assign enable_w[5] = pins7_8_config_q[`GPC_HI_EN];                         // see RULE_06
  assign remote_w[5:2] = 4'h0;                                                // see RULE_09

  // ********************************************************************
  // Pad controllers
  // ********************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < GPC_NUM_PADS; gi++) begin : g_pad
      gpc_pin_ctrl u_pin (
        .clk_i        (clk_i),
        .sys_rst_i    (sys_rst_i),
        .mode_i       (gpc_mode_e'({orient_w[gi], enable_w[gi]})),  // see RULE_04
        .level_i      (level_w[gi]),                                // see RULE_02
        .remote_en_i  (remote_w[gi]),                               // see RULE_03
        .remote_val_i (remote_pin3_i),
        .func_i       (func_i[gi]),
        .pad_i        (pad_i[gi]),
        .pad_o        (pad_o[gi]),
        .pad_oe_n_o   (pad_oe_n_o[gi]),
        .in_level_o   (in_levels[gi])
      );
    end
  endgenerate

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_port_steer: assert property ( // see RULE_01
    $past(sel && pin3_config_q[2:0] == 3'h1)
      |-> !pad_oe_n_o[1] && pad_o[1] == $past(p3_lvl) && pad_oe_n_o[0])
    else $error("Second port pin 3 not steered by pin 3 register");
  a_strap_code: assert property ( // see RULE_05
    init_q && !$past(init_q) && $past(sel) |-> pin3_config_q[1:0] == 2'h3)
    else $error("Pin 3 mode not strapped to 11 with select high");
  a_map_upper: assert property ( // see RULE_06
    $past(pins5_6_config_q[5:4] == 2'h1)
      |-> !pad_oe_n_o[3] && pad_o[3] == $past(pins5_6_config_q[7]))
    else $error("Upper pin of pins 5/6 field map wrong");
  a_map_lower: assert property ( // see RULE_07
    $past(pins7_8_config_q[1:0] == 2'h2) |-> pad_oe_n_o[4])
    else $error("Lower pin of pins 7/8 mode code wrong");
  a_reg_addr: assert property ( // see RULE_08
    wr_p78 |=> pins7_8_config_q == $past(avs_writedata_i[7:0]))
    else $error("Write to pins 7/8 register not stored");
  a_reserved_zero: assert property ( // see RULE_09
    $past(capture && hit_pin3) |-> avs_readdata_o[31:4] == 28'h0000000)
    else $error("Reserved bits of pin 3 read nonzero");
  a_wait_once: assert property (
    capture |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("Wait request did not drop for exactly one cycle");

  c_remote_drive: cover property (remote_w[0] ##1 !pad_oe_n_o[0]);
  c_strap_seen: cover property (init_q && !$past(init_q) && $past(sel));
  c_read_done: cover property (avs_read_i && !avs_waitrequest_o);
  c_write_p56: cover property (wr_p56);

endmodule // gpc_pin_config_bank

//--- rtl/gpc_params.svh
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH

// ********************************************************************
// Register indices (byte address is four times the index)
// ********************************************************************
`define GPC_IDX_PIN3      6'h1F
`define GPC_IDX_PINS5_6   6'h20
`define GPC_IDX_PINS7_8   6'h21
`define GPC_IDX_IN_LEVELS 6'h30

// ********************************************************************
// Reset values and masks
// ********************************************************************
`define GPC_RST_CFG       8'h00
`define GPC_PIN3_RW_MASK  8'h0F
`define GPC_STRAP_CODE    2'h3

// ********************************************************************
// Field positions
// ********************************************************************
`define GPC_HI_LEVEL      7
`define GPC_HI_DIR        5
`define GPC_HI_EN         4
`define GPC_LO_LEVEL      3
`define GPC_LO_REMOTE     2
`define GPC_LO_DIR        1
`define GPC_LO_EN         0

`endif

//--- rtl/gpc_pkg.sv
package gpc_pkg;

  // Pad mode, coded as {orientation, pad enable}
  typedef enum logic [1:0] {
    GPC_FUNC_OUT = 2'h0,
    GPC_GPIO_OUT = 2'h1,
    GPC_TRISTATE = 2'h2,
    GPC_GPIO_IN  = 2'h3
  } gpc_mode_e;

  localparam int GPC_NUM_PADS = 6;

endpackage

//--- rtl/gpc_pin_ctrl.sv
module gpc_pin_ctrl (
  input  wire logic              clk_i,        // System clock
  input  wire logic              sys_rst_i,    // Async reset, active high
  input  wire gpc_pkg::gpc_mode_e mode_i,      // {orientation, pad enable}
  input  wire logic              level_i,      // Stored local output level
  input  wire logic              remote_en_i,  // Remote drive enable
  input  wire logic              remote_val_i, // Value from remote serializer
  input  wire logic              func_i,       // Functional output value
  input  wire logic              pad_i,        // Pad input level
  output logic                   pad_o,        // Pad output level
  output logic                   pad_oe_n_o,   // Pad drive enable, low drives
  output logic                   in_level_o    // Sampled pad level
);
  import gpc_pkg::*;

  // ********************************************************************
  // Drive selection
  // ********************************************************************
  logic pad_d;
  logic oe_n_d;

  // Remote drive outranks the mode code entirely
  assign pad_d  = remote_en_i ? remote_val_i :                   // see RULE_03
                  (mode_i == GPC_GPIO_OUT) ? level_i :           // see RULE_02
                  (mode_i == GPC_FUNC_OUT) ? func_i : 1'b0;      // see RULE_04
  assign oe_n_d = remote_en_i ? 1'b0 :                           // see RULE_03
                  mode_i[1];                                     // see RULE_04

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pad_o      <= 1'b0;
      pad_oe_n_o <= 1'b1;
      in_level_o <= 1'b0;
    end else begin
      pad_o      <= pad_d;
      pad_oe_n_o <= oe_n_d;
      in_level_o <= pad_i;
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // The edge after reset release still shows the reset pad state, so it is skipped
  a_gpio_drive: assert property ( // see RULE_02
    $past(!sys_rst_i && mode_i == GPC_GPIO_OUT && !remote_en_i)
      |-> !pad_oe_n_o && pad_o == $past(level_i))
    else $error("GPIO output mode does not drive local level");
  a_remote_force: assert property ( // see RULE_03
    $past(!sys_rst_i && remote_en_i) |-> !pad_oe_n_o && pad_o == $past(remote_val_i))
    else $error("Remote drive not forced onto pad");
  a_mode_float: assert property ( // see RULE_04
    $past(!sys_rst_i && !remote_en_i && mode_i[1]) |-> pad_oe_n_o)
    else $error("Pad driven in tri-state or input mode");
  a_func_pass: assert property ( // see RULE_04
    $past(!sys_rst_i && !remote_en_i && mode_i == GPC_FUNC_OUT)
      |-> !pad_oe_n_o && pad_o == $past(func_i))
    else $error("Functional mode does not pass functional value");

endmodule // gpc_pin_ctrl

//--- testbench/gpc_remote_model.sv
module gpc_remote_model (
  input  wire logic clk_i,     // System clock
  input  wire logic sys_rst_i, // Async reset, active high
  input  wire logic want_i,    // Level the bench wants sent
  output logic      remote_o   // Pin value received over the link
);
  timeunit 1ns;
  timeprecision 1ps;
  // One cycle of link latency, so the pad never sees the request early
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      remote_o <= 1'b0;
    end else begin
      remote_o <= want_i;
    end
  end
endmodule // gpc_remote_model

//--- testbench/gpc_pin_config_bank_bench.sv
module gpc_pin_config_bank_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, sys_rst_i, rd, wr, waitreq, sel, want, remote;
  logic [7:0]  addr, v;
  logic [31:0] wdata, rdata, got;
  logic [3:0]  be;
  logic [5:0]  func, pad_in, pad_o, oe_n;
  logic [1:0]  hi, lo;
  int          fails, n_compared, cycles;

  gpc_pin_config_bank gpc_pin_config_bank_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .second_port_select_i(sel),
    .remote_pin3_i(remote), .func_i(func), .pad_i(pad_in), .pad_o(pad_o),
    .pad_oe_n_o(oe_n));

  gpc_remote_model gpc_remote_model_i (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .want_i(want), .remote_o(remote));

  // ******************************************************************
  // Bus and compare tasks
  // ******************************************************************
  task automatic report_and_stop();
    if (fails == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Request held until waitrequest is seen low; the timeout ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] b);
    @(posedge clk_i);
    addr  <= a;
    wdata <= {24'h0, d};
    be    <= b;
    rd    <= !w;
    wr    <= w;
    do @(posedge clk_i); while (waitreq !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(got, {24'h0, e});
  endtask

  // Pads follow the register one edge late; three edges leave margin
  task automatic pads_chk(input logic [5:0] m, input logic [5:0] eo, input logic [5:0] en);
    repeat (3) @(posedge clk_i);
    chk({26'h0, pad_o & m}, {26'h0, eo});
    chk({26'h0, oe_n & m}, {26'h0, en});
  endtask

  // Expected {oe_n, level} for a mode with stored level 1
  function automatic logic [1:0] drv(input logic [1:0] md, input logic f);
    case (md)
      2'h0:    drv = {1'b0, f};
      2'h1:    drv = 2'b01;
      default: drv = 2'b10;
    endcase
  endfunction

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    {rd, wr, want, addr, wdata, be} = '0;
    sys_rst_i = 1'b1;
    sel = 1'b1;
    func = 6'h14;
    pad_in = 6'h2A;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd_chk(8'h7C, 8'h03);
    rd_chk(8'h80, 8'h00);
    rd_chk(8'h84, 8'h00);
    rd_chk(8'h88, 8'h00);
    rd_chk(8'hC0, 8'h2A);
    pads_chk(6'h3F, 6'h14, 6'h03);
    bus(1'b1, 8'h7C, 8'hF7, 4'h1);
    rd_chk(8'h7C, 8'h07);
    want <= 1'b1;
    pads_chk(6'h03, 6'h02, 6'h01);
    want <= 1'b0;
    pads_chk(6'h03, 6'h00, 6'h01);
    bus(1'b1, 8'h7C, 8'h09, 4'h1);
    pads_chk(6'h03, 6'h02, 6'h01);
    sel <= 1'b0;
    pads_chk(6'h03, 6'h01, 6'h02);
    bus(1'b1, 8'h7C, 8'h0D, 4'h1);
    pads_chk(6'h03, 6'h00, 6'h02);
    want <= 1'b1;
    pads_chk(6'h03, 6'h01, 6'h02);
    bus(1'b1, 8'h7C, 8'h0B, 4'h1);
    pads_chk(6'h03, 6'h00, 6'h03);
    bus(1'b1, 8'h80, 8'hFF, 4'hE);
    rd_chk(8'h80, 8'h00);
    // Upper and lower pins get different modes so a swapped field shows
    for (int m = 0; m < 4; m++) begin
      v = 8'hCC | 8'(m << 4) | 8'(3 - m);
      bus(1'b1, 8'h80, v, 4'h1);
      bus(1'b1, 8'h84, v, 4'h1);
      rd_chk(8'h80, v);
      rd_chk(8'h84, v);
      hi = drv(2'(m), 1'b0);
      lo = drv(2'(3 - m), 1'b1);
      pads_chk(6'h3C, {hi[0], lo[0], hi[0], lo[0], 2'b00},
               {hi[1], lo[1], hi[1], lo[1], 2'b00});
    end
    // Second reset with select low: no strap, written registers cleared
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd_chk(8'h7C, 8'h00);
    rd_chk(8'h84, 8'h00);
    pads_chk(6'h3F, 6'h14, 6'h02);
    report_and_stop();
  end
endmodule // gpc_pin_config_bank_bench
